// ==== verilog/pcs_pkg.sv ====
package pcs_pkg;

  // ==========================================================
  // Cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 20;
  // Least times, so each rounds up to whole cycles.
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // ==========================================================
  // Queue and pin levels
  localparam int FIFO_DEPTH = 32;
  localparam logic PIN_OFF = 1'h1;
  localparam logic SYNC_RST = 1'h1;

  // ==========================================================
  // Commands and pins
  typedef enum logic [2:0] {
    KIND_MEM_RD = 3'h0,
    KIND_MEM_WR = 3'h1,
    KIND_ATTR_RD = 3'h2,
    KIND_ATTR_WR = 3'h3,
    KIND_IO_RD = 3'h4,
    KIND_IO_WR = 3'h5,
    KIND_DMA_TO_CARD = 3'h6,
    KIND_DMA_TO_HOST = 3'h7
  } pcs_kind_t;

  typedef struct packed {
    pcs_kind_t kind;
    logic last;
  } pcs_cmd_t;

  typedef struct packed {
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic attr_sel_n;
  } pcs_pins_t;

  localparam pcs_pins_t PINS_IDLE = 5'h1F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_WAIT = 3'h7,
    ST_HOLD = 3'h2
  } pcs_state_t;

endpackage : pcs_pkg

// ==== verilog/pcs_fifo.sv ====
`timescale 1ns/100ps
module pcs_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("pcs_fifo needs a power-of-two depth of two or more");
    end
  endgenerate

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic in_ready_ff;
  wire push = in_valid & in_ready_ff;
  wire pop = out_ready & (count_ff != '0);
  wire [AW:0] nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready = in_ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  // ==========================================================
  // Storage and pointers
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      count_ff <= nxt_count;
      // Registered so that a full queue refuses the very next push.
      in_ready_ff <= (nxt_count < (AW + 1)'(DEPTH));
    end
  end

endmodule : pcs_fifo

// ==== verilog/pcs_socket.sv ====
`timescale 1ns/100ps
// Functional notes
// - Host I/O reads pull the I/O read strobe low so the card drives data.
// - Card-to-host DMA uses the I/O read strobe as the transfer strobe.
// - Host I/O writes pull the I/O write strobe low to latch write data.
// - Host-to-card DMA uses the I/O write strobe as the transfer strobe.
// - Host memory reads pull the memory read strobe low so the card drives data.
// - Card-to-host DMA marks its terminal count on the memory read strobe.
// - The shared ready line counts as ready only in memory-only mode.
// - The attribute select stays high for every common memory access.
// - Attribute select with memory strobes hits attribute space, with I/O strobes I/O.
// - DMA asserts the attribute select as its grant, with the matching I/O strobe.
// - Host-to-card DMA marks its terminal count on the memory write strobe.
// - A card stretches a cycle with wait and the socket holds until it is released.
module pcs_socket #(
  parameter int FIFO_DEPTH = pcs_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire pcs_pkg::pcs_cmd_t cmd,
  input wire logic mem_only,
  input wire logic io_read_claim_n,
  input wire logic card_ready_irq,
  input wire logic wait_n,
  output pcs_pkg::pcs_pins_t pins,
  output logic done,
  output logic claimed,
  output logic card_ready,
  output logic card_irq_request,
  output logic busy
);

  generate
    if (pcs_pkg::SETUP_CYC < 1 || pcs_pkg::STROBE_CYC < 1 ||
        pcs_pkg::HOLD_CYC < 1 || pcs_pkg::STROBE_CYC > 255)
    begin : g_bad
      $error("pcs_socket timing counts do not fit the counter");
    end
  endgenerate

  // ==========================================================
  // Command queue
  logic fifo_valid;
  logic fifo_take;
  logic [$bits(pcs_pkg::pcs_cmd_t)-1:0] fifo_raw;
  logic cmd_ready_w;
  pcs_pkg::pcs_cmd_t fifo_cmd;

  pcs_fifo #(
    .WIDTH($bits(pcs_pkg::pcs_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready_w),
    .in_data(cmd),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_raw)
  );

  assign fifo_cmd = pcs_pkg::pcs_cmd_t'(fifo_raw);
  assign cmd_ready = cmd_ready_w;

  // ==========================================================
  // Pin synchronisers
  // The card lines are asynchronous to sys_clk, so each passes two flops.
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  wire [2:0] pin_raw = {io_read_claim_n, card_ready_irq, wait_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          sync1_ff[gi] <= pcs_pkg::SYNC_RST;
          sync2_ff[gi] <= pcs_pkg::SYNC_RST;
        end
        else
        begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire claim_s_n = sync2_ff[2];
  wire ready_s = sync2_ff[1];
  wire wait_s_n = sync2_ff[0];

  // ==========================================================
  // Cycle sequencer
  pcs_pkg::pcs_state_t state_ff;
  pcs_pkg::pcs_state_t nxt_state;
  logic [pcs_pkg::CNT_W-1:0] cnt_ff;
  logic [pcs_pkg::CNT_W-1:0] nxt_cnt;
  pcs_pkg::pcs_cmd_t cmd_ff;
  logic nxt_done;

  wire pcs_pkg::pcs_kind_t head_kind = fifo_cmd.kind;
  wire head_mem_wr = (head_kind == pcs_pkg::KIND_MEM_WR) ||
                     (head_kind == pcs_pkg::KIND_ATTR_WR);
  wire head_dma = (head_kind == pcs_pkg::KIND_DMA_TO_CARD) ||
                  (head_kind == pcs_pkg::KIND_DMA_TO_HOST);
  // A memory write waits for ready, which only means ready in memory-only mode.
  wire ready_gate = ~(mem_only & head_mem_wr) | ready_s;
  // DMA data moves only while the card requests on its claim line.
  wire dma_gate = ~head_dma | ~claim_s_n;
  wire start_ok = fifo_valid & ready_gate & dma_gate;
  wire cnt_done = (cnt_ff == pcs_pkg::CNT_ZERO);
  wire [pcs_pkg::CNT_W-1:0] cnt_dec = cnt_ff - 8'h01;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    fifo_take = 1'b0;
    nxt_done = 1'b0;
    case (state_ff)
      pcs_pkg::ST_IDLE:
      begin
        if (start_ok)
        begin
          nxt_state = pcs_pkg::ST_SETUP;
          nxt_cnt = pcs_pkg::SETUP_LD;
          fifo_take = 1'b1;
        end
      end
      pcs_pkg::ST_SETUP:
      begin
        if (cnt_done)
        begin
          nxt_state = pcs_pkg::ST_STROBE;
          nxt_cnt = pcs_pkg::STROBE_LD;
        end
        else
        begin
          nxt_cnt = cnt_dec;
        end
      end
      pcs_pkg::ST_STROBE:
      begin
        if (!cnt_done)
        begin
          nxt_cnt = cnt_dec;
        end
        else if (!wait_s_n)
        begin
          nxt_state = pcs_pkg::ST_WAIT;
        end
        else
        begin
          nxt_state = pcs_pkg::ST_HOLD;
          nxt_cnt = pcs_pkg::HOLD_LD;
        end
      end
      pcs_pkg::ST_WAIT:
      begin
        if (wait_s_n)
        begin
          nxt_state = pcs_pkg::ST_HOLD;
          nxt_cnt = pcs_pkg::HOLD_LD;
        end
      end
      pcs_pkg::ST_HOLD:
      begin
        if (cnt_done)
        begin
          nxt_state = pcs_pkg::ST_IDLE;
          nxt_done = 1'b1;
        end
        else
        begin
          nxt_cnt = cnt_dec;
        end
      end
      default:
      begin
        nxt_state = pcs_pkg::ST_IDLE;
        nxt_cnt = pcs_pkg::CNT_ZERO;
      end
    endcase
  end

  // ==========================================================
  // Pin decode
  // Decoded from the next state so the pin flops line up with state_ff.
  wire pcs_pkg::pcs_cmd_t cmd_sel = fifo_take ? fifo_cmd : cmd_ff;
  wire pcs_pkg::pcs_kind_t k = cmd_sel.kind;
  wire active = (nxt_state != pcs_pkg::ST_IDLE);
  wire strobing = (nxt_state == pcs_pkg::ST_STROBE) ||
                  (nxt_state == pcs_pkg::ST_WAIT);
  wire k_mrd = (k == pcs_pkg::KIND_MEM_RD) || (k == pcs_pkg::KIND_ATTR_RD);
  wire k_mwr = (k == pcs_pkg::KIND_MEM_WR) || (k == pcs_pkg::KIND_ATTR_WR);
  wire k_to_host = (k == pcs_pkg::KIND_DMA_TO_HOST);
  wire k_to_card = (k == pcs_pkg::KIND_DMA_TO_CARD);
  wire k_common = (k == pcs_pkg::KIND_MEM_RD) || (k == pcs_pkg::KIND_MEM_WR);
  wire rd_low = strobing & (k_mrd | (k_to_host & cmd_sel.last));
  wire wr_low = strobing & (k_mwr | (k_to_card & cmd_sel.last));
  wire io_read_strobe_low = strobing & ((k == pcs_pkg::KIND_IO_RD) | k_to_host);
  wire io_write_strobe_low = strobing & ((k == pcs_pkg::KIND_IO_WR) | k_to_card);
  // Everything except common memory selects attribute or I/O space or DMA.
  wire attr_low = active & ~k_common;
  wire pcs_pkg::pcs_pins_t nxt_pins = {~rd_low, ~wr_low, ~io_read_strobe_low, ~io_write_strobe_low,
                                       ~attr_low};

  wire leave_strobe = ((state_ff == pcs_pkg::ST_STROBE) ||
                       (state_ff == pcs_pkg::ST_WAIT)) &&
                      (nxt_state == pcs_pkg::ST_HOLD);

  // ==========================================================
  // Registers
  pcs_pkg::pcs_pins_t pins_ff;
  logic done_ff;
  logic claimed_ff;
  logic card_ready_ff;
  logic irq_ff;
  logic busy_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= pcs_pkg::ST_IDLE;
      cnt_ff <= pcs_pkg::CNT_ZERO;
      cmd_ff <= '0;
      pins_ff <= pcs_pkg::PINS_IDLE;
      done_ff <= 1'b0;
      claimed_ff <= 1'b0;
      card_ready_ff <= 1'b0;
      irq_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cmd_ff <= cmd_sel;
      pins_ff <= nxt_pins;
      done_ff <= nxt_done;
      busy_ff <= active;
      card_ready_ff <= mem_only & ready_s;
      irq_ff <= ~mem_only & ~ready_s;
      if (leave_strobe)
      begin
        // The claim is only meaningful for a host I/O read.
        claimed_ff <= (cmd_ff.kind == pcs_pkg::KIND_IO_RD) & ~claim_s_n;
      end
    end
  end

  assign pins = pins_ff;
  assign done = done_ff;
  assign claimed = claimed_ff;
  assign card_ready = card_ready_ff;
  assign card_irq_request = irq_ff;
  assign busy = busy_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  wire in_strobe = (state_ff == pcs_pkg::ST_STROBE);
  wire pcs_pkg::pcs_kind_t ck = cmd_ff.kind;

  sequence strobe_open_s;
    $rose(in_strobe);
  endsequence
  sequence strobe_held_s;
    in_strobe [*8];
  endsequence

  idle_pins_a: assert property (
    (state_ff == pcs_pkg::ST_IDLE) |-> (pins_ff == pcs_pkg::PINS_IDLE))
    else $error("strobes not at rest in idle");
  strobe_len_a: assert property (
    strobe_open_s |-> strobe_held_s)
    else $error("strobe phase shorter than eight cycles");
  common_attr_a: assert property (
    (ck == pcs_pkg::KIND_MEM_RD || ck == pcs_pkg::KIND_MEM_WR) |-> pins_ff.attr_sel_n)
    else $error("attribute select low on common memory");
  io_read_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_IO_RD) |->
      (!pins_ff.io_read_strobe_n && !pins_ff.attr_sel_n && pins_ff.mem_read_strobe_n))
    else $error("I/O read strobe missing");
  io_write_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_IO_WR) |->
      (!pins_ff.io_write_strobe_n && pins_ff.io_read_strobe_n))
    else $error("I/O write strobe missing");
  mem_read_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_MEM_RD) |->
      (!pins_ff.mem_read_strobe_n && pins_ff.attr_sel_n))
    else $error("memory read strobe missing");
  dma_host_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_DMA_TO_HOST) |->
      (!pins_ff.io_read_strobe_n && !pins_ff.attr_sel_n))
    else $error("card-to-host DMA strobe or grant missing");
  dma_card_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_DMA_TO_CARD) |->
      (!pins_ff.io_write_strobe_n && !pins_ff.attr_sel_n))
    else $error("host-to-card DMA strobe or grant missing");
  tc_host_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_DMA_TO_HOST) |->
      (pins_ff.mem_read_strobe_n == !cmd_ff.last))
    else $error("terminal count wrong on memory read strobe");
  tc_card_a: assert property (
    (in_strobe && ck == pcs_pkg::KIND_DMA_TO_CARD) |->
      (pins_ff.mem_write_strobe_n == !cmd_ff.last))
    else $error("terminal count wrong on memory write strobe");
  wait_hold_a: assert property (
    ((in_strobe || state_ff == pcs_pkg::ST_WAIT) && !wait_s_n) |=>
      (state_ff == pcs_pkg::ST_STROBE || state_ff == pcs_pkg::ST_WAIT))
    else $error("cycle completed while wait held");
  ready_gate_a: assert property (
    (fifo_take && mem_only && head_mem_wr) |-> ready_s)
    else $error("memory write started while card busy");
  attr_space_a: assert property (
    (state_ff != pcs_pkg::ST_IDLE &&
     (ck == pcs_pkg::KIND_ATTR_RD || ck == pcs_pkg::KIND_IO_RD)) |-> !pins_ff.attr_sel_n)
    else $error("attribute select high for attribute or I/O cycle");

endmodule : pcs_socket

// ==== verif/pcs_card.sv ====
`timescale 1ns/100ps
// ==========================================================
// Card model on the far side of the socket pins
module pcs_card (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pcs_pkg::pcs_pins_t pins,
  input wire logic mem_only,
  input wire logic dma_req,
  input wire logic claim_en,
  input wire logic mem_busy,
  input wire logic irq_req,
  input wire logic [7:0] wait_len,
  output logic io_read_claim_n,
  output logic card_ready_irq,
  output logic wait_n
);
  logic strobe_low;
  logic strobe_ff;
  logic [7:0] wait_ff;
  assign strobe_low = (pins[4:1] != 4'hF);
  // A claim follows the read strobe while claim_en is set, and dma_req alone also holds it low.
  assign io_read_claim_n = !(dma_req | (claim_en & !pins.io_read_strobe_n));
  assign card_ready_irq = mem_only ? !mem_busy : !irq_req;
  assign wait_n = (wait_ff == 8'h00);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strobe_ff <= 1'h0;
      wait_ff <= 8'h00;
    end
    else
    begin
      strobe_ff <= strobe_low;
      if (strobe_low && !strobe_ff)
        wait_ff <= wait_len;
      else if (wait_ff != 8'h00)
        wait_ff <= wait_ff - 8'h01;
    end
  end
endmodule : pcs_card

// ==== verif/tb_pcs_socket.sv ====
`timescale 1ns/100ps
module tb_pcs_socket;
  logic sys_clk, rst, cmd_valid, cmd_ready, mem_only, io_read_claim_n, card_ready_irq;
  logic wait_n, done, claimed, card_ready, card_irq_request, busy;
  logic dma_req, claim_en, mem_busy, irq_req;
  logic [7:0] wait_len;
  pcs_pkg::pcs_cmd_t cmd;
  pcs_pkg::pcs_pins_t pins;
  pcs_pkg::pcs_pins_t acc;
  logic [5:0] exp_q[$];
  logic [5:0] e;
  int err_count, n_checks, cyc, scnt, k, n, r;
  bit ok;

  pcs_socket u_pcs_socket (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .mem_only(mem_only), .io_read_claim_n(io_read_claim_n),
    .card_ready_irq(card_ready_irq), .wait_n(wait_n), .pins(pins), .done(done),
    .claimed(claimed), .card_ready(card_ready), .card_irq_request(card_irq_request),
    .busy(busy));
  pcs_card u_pcs_card (.sys_clk(sys_clk), .rst(rst), .pins(pins), .mem_only(mem_only),
    .dma_req(dma_req), .claim_en(claim_en), .mem_busy(mem_busy), .irq_req(irq_req),
    .wait_len(wait_len), .io_read_claim_n(io_read_claim_n),
    .card_ready_irq(card_ready_irq), .wait_n(wait_n));

  // ==========================================================
  // Compare tasks and reference model
  task automatic chk_pins(input pcs_pkg::pcs_pins_t got, input pcs_pkg::pcs_pins_t exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t pins %h expected %h", $time, got, exp);
    end
  endtask : chk_pins

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("MISMATCH t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_cnt

  function automatic pcs_pkg::pcs_pins_t exp_pins(input logic [3:0] c);
    pcs_pkg::pcs_pins_t p;
    int t;
    t = c[3:1];
    p.attr_sel_n = (t < 2);
    p.mem_read_strobe_n = !(t == 0 || t == 2 || (t == 7 && c[0]));
    p.mem_write_strobe_n = !(t == 1 || t == 3 || (t == 6 && c[0]));
    p.io_read_strobe_n = !(t == 4 || t == 7);
    p.io_write_strobe_n = !(t == 5 || t == 6);
    return p;
  endfunction : exp_pins

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // ==========================================================
  // Drivers
  task automatic push(input logic [3:0] c, input int maxw, output bit acc_ok);
    int t;
    t = 0;
    @(negedge sys_clk);
    cmd_valid = 1'h1;
    cmd = c;
    @(posedge sys_clk);
    while (cmd_ready !== 1'h1 && t < maxw)
    begin
      t++;
      @(posedge sys_clk);
    end
    acc_ok = (cmd_ready === 1'h1);
    if (acc_ok)
      exp_q.push_back({wait_len > 8'h14, claim_en | dma_req, c});
  endtask : push

  task automatic drain();
    int t;
    t = 0;
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    while (exp_q.size() != 0 && t < 4000)
    begin
      t++;
      @(posedge sys_clk);
    end
    chk_cnt(exp_q.size(), 0, 0);
  endtask : drain

  // ==========================================================
  // Monitor: every finished cycle is held against the model
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
    if (!rst && done === 1'h1)
    begin
      chk_bit(busy, 1'h0);
      if (exp_q.size() == 0)
        chk_cnt(1, 0, 0);
      else
      begin
        e = exp_q.pop_front();
        chk_pins(acc, exp_pins(e[3:0]));
        chk_pins(pins, pcs_pkg::PINS_IDLE);
        chk_cnt(scnt, e[5] ? 21 : 20, e[5] ? 200 : 20);
        if (e[3:1] == 3'h4)
          chk_bit(claimed, e[4]);
      end
      acc = pcs_pkg::PINS_IDLE;
      scnt = 0;
    end
    else
    begin
      acc = acc & pins;
      if (pins[4:1] != 4'hF)
      begin
        scnt++;
        chk_bit(busy, 1'h1);
      end
    end
  end

  initial
  begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd = 4'h0;
    mem_only = 1'h0;
    dma_req = 1'h1;
    claim_en = 1'h1;
    mem_busy = 1'h0;
    irq_req = 1'h0;
    wait_len = 8'h00;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    scnt = 0;
    acc = pcs_pkg::PINS_IDLE;
    n = $urandom(45);
    repeat (6) @(negedge sys_clk);
    rst = 1'h0;
    repeat (2) @(posedge sys_clk);
    for (k = 0; k < 16; k++)
      push(k[3:0], 200, ok);
    drain();
    $display("test every kind back to back done");
    @(negedge sys_clk);
    dma_req = 1'h0;
    claim_en = 1'h0;
    push(4'h8, 200, ok);
    push(4'hD, 200, ok);
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    repeat (120) @(posedge sys_clk);
    chk_cnt(exp_q.size(), 1, 1);
    @(negedge sys_clk);
    dma_req = 1'h1;
    drain();
    @(negedge sys_clk);
    dma_req = 1'h0;
    claim_en = 1'h1;
    push(4'h8, 200, ok);
    drain();
    $display("test claim and dma request done");
    for (k = 0; k < 2; k++)
    begin
      wait_len = k ? 8'h28 : 8'h0A;
      push(4'h0, 200, ok);
      push(4'h8, 200, ok);
      drain();
    end
    wait_len = 8'h00;
    $display("test wait stretch done");
    @(negedge sys_clk);
    mem_only = 1'h1;
    mem_busy = 1'h1;
    dma_req = 1'h1;
    repeat (5) @(posedge sys_clk);
    chk_bit(card_ready, 1'h0);
    push(4'h2, 200, ok);
    n = 1;
    for (k = 0; k < 40 && ok; k++)
    begin
      r = $urandom;
      push(r[3:0], 0, ok);
      if (ok)
        n++;
    end
    chk_cnt(n, pcs_pkg::FIFO_DEPTH, pcs_pkg::FIFO_DEPTH);
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    mem_busy = 1'h0;
    repeat (5) @(posedge sys_clk);
    chk_bit(card_ready, 1'h1);
    drain();
    $display("test full queue done");
    @(negedge sys_clk);
    mem_only = 1'h0;
    irq_req = 1'h1;
    repeat (5) @(posedge sys_clk);
    chk_bit(card_irq_request, 1'h1);
    chk_bit(card_ready, 1'h0);
    @(negedge sys_clk);
    irq_req = 1'h0;
    repeat (5) @(posedge sys_clk);
    chk_bit(card_irq_request, 1'h0);
    $display("test ready and interrupt done");
    results();
  end
endmodule : tb_pcs_socket
